// *** hw/ppl_fifo.v ***
`default_nettype none

// ===
// Word FIFO whose head word and valid
// come straight from flip-flops.
module ppl_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire pclk, // System clock.
    input wire presetn, // Asynchronous reset, active low.
    input wire [WIDTH-1:0] in_data, // Word to store.
    input wire in_valid, // Word offered.
    output wire in_ready, // Room for a word.
    output reg [WIDTH-1:0] out_data_r, // Head word.
    output reg out_valid_r, // Head word present.
    input wire out_ready // Drain accepts the head word.
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage behind the head register.
    reg [AW-1:0] wr_ptr_r; // Next slot to write.
    reg [AW-1:0] rd_ptr_r; // Next slot to read.
    reg [AW:0] cnt_r; // Words held in storage.
    wire push; // A word enters storage.
    wire load_out; // Storage feeds the head register.

    // Full is honest: the head register is extra room, not counted.
    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign push = in_valid & in_ready;
    assign load_out = (~out_valid_r | out_ready) & (cnt_r != {(AW+1){1'b0}});

    // Storage write; no reset needed.
    always @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers, count and head register.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            out_valid_r <= 1'b0;
            out_data_r <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (load_out) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
                out_data_r <= mem[rd_ptr_r];
                out_valid_r <= 1'b1;
            end else if (out_ready) begin
                out_valid_r <= 1'b0;
            end
            if (push & ~load_out) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (load_out & ~push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** hw/ppl_loader.v ***
// What this block does
// (R01) User mode leaves status and done lines high.
// (R02) Request low abandons user mode, restarts load.
// (R03) Status held low through power-on delay.
// (R04) Done line low from power-up until loaded.
// (R05) Host sends the whole bitstream.
// (R06) Host sizes transfer to the part's length.
// (R07) Done released only after error-free full load.
// (R08) Host gives two falling edges after done.
// (R09) Load clock ignored once configured.
// (R10) Host keeps load clock driven afterwards.
// (R11) 16-bit uses bits 15:0, 8-bit bits 7:0.
// (R12) Data bus becomes user input afterwards.
// (R13) Enabled init-done output driven low when configured.
// (R14) Host may pause by holding clock low.
// (R15) Host sets data before resuming rising edge.
// (R16) Ratio r follows decompression and security.
// (R17) Ratio one captures a word every rising edge.
// (R18) Ratio r holds each word r cycles.
`include "ppl_consts.vh"
`default_nettype none

module ppl_loader #(
    parameter POR_CYCLES = `PPL_POR_CYCLES
) (
    input wire pclk, // System clock, 200 MHz.
    input wire presetn, // Asynchronous reset, active low.
    input wire psel, // APB select.
    input wire penable, // APB access phase.
    input wire pwrite, // APB write.
    input wire [11:0] paddr, // APB byte address.
    input wire [31:0] pwdata, // APB write data.
    output reg [31:0] prdata, // APB read data.
    output reg pready, // APB ready.
    output reg pslverr, // APB error for unmapped address.
    input wire load_clock, // Host-driven load clock pin.
    input wire cfg_req_n, // Reconfiguration request, active low.
    input wire [31:0] load_data, // Parallel data pins.
    input wire cfg_status_n_i, // Status line level.
    output reg cfg_status_n_o, // Status line drive value.
    output reg cfg_status_n_oe_n, // Status line enable, low drives.
    input wire load_done_i, // Load-complete line level.
    output reg load_done_o, // Load-complete drive value.
    output reg load_done_oe_n, // Load-complete enable, low drives.
    output reg init_done_o, // Init-complete drive value.
    output reg init_done_oe_n, // Init-complete enable, low drives.
    output wire [31:0] cfg_word, // Loaded word to the fabric.
    output wire cfg_valid, // Loaded word present.
    input wire cfg_ready, // Fabric takes the word.
    output reg [31:0] user_data_r, // Data pins as user input.
    output reg user_mode_r // Device is in user mode.
);
    // ===
    // Decoding helpers.

    // Cycles per word from the feature options.
    function [3:0] ratio_f;
        input decomp;
        input secure;
        begin
            ratio_f = (decomp | secure) ? `PPL_RATIO_FEAT : `PPL_RATIO_PLAIN; // R16
        end
    endfunction

    // Live data lanes for a width code.
    function [31:0] lanes_f;
        input [1:0] width;
        input [31:0] data;
        begin
            case (width)
                `PPL_WIDTH_8: lanes_f = {24'h00_0000, data[7:0]}; // R11
                `PPL_WIDTH_16: lanes_f = {16'h0000, data[15:0]}; // R11
                default: lanes_f = data;
            endcase
        end
    endfunction

    // ===
    // Declarations.
    reg [1:0] lclk_s_r; // Load clock synchroniser.
    reg lclk_d_r; // Previous synchronised load clock.
    reg [1:0] req_s_r; // Request synchroniser.
    reg [1:0] stat_s_r; // Status line synchroniser.
    reg [1:0] done_s_r; // Load-complete line synchroniser.
    reg [31:0] data_s1_r; // Data pins, first stage.
    reg [31:0] data_s2_r; // Data pins, second stage.
    reg [7:0] ctrl_r; // Control register.
    reg [31:0] len_r; // Expected transfer count.
    reg [2:0] state_r; // Controller state.
    reg [2:0] state_nxt;
    reg [31:0] por_cnt_r; // Power-on delay counter.
    reg [31:0] por_cnt_nxt;
    reg [3:0] phase_r; // Rising edges into the current word.
    reg [3:0] phase_nxt;
    reg [31:0] count_r; // Words taken so far.
    reg [31:0] count_nxt;
    reg [1:0] fall_r; // Falling edges seen after done.
    reg [1:0] fall_nxt;
    reg push; // Word goes to the FIFO.
    wire fifo_ready; // FIFO has room.
    wire lclk_rise; // Load clock rising edge.
    wire lclk_fall; // Load clock falling edge.
    wire [3:0] ratio; // Current cycles per word.
    wire apb_access; // First access cycle of an APB transfer.

    assign lclk_rise = lclk_s_r[1] & ~lclk_d_r;
    assign lclk_fall = ~lclk_s_r[1] & lclk_d_r;
    assign ratio = ratio_f(ctrl_r[`PPL_CTRL_DECOMP_BIT], ctrl_r[`PPL_CTRL_SECURE_BIT]);
    assign apb_access = psel & penable & ~pready;

    // ===
    // Pin synchronisers. Every pin passes two flops;
    // only the second stage is read.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lclk_s_r <= 2'h0;
            lclk_d_r <= 1'b0;
            req_s_r <= 2'h3;
            stat_s_r <= 2'h0;
            done_s_r <= 2'h0;
            data_s1_r <= 32'h0000_0000;
            data_s2_r <= 32'h0000_0000;
        end else begin
            lclk_s_r <= {lclk_s_r[0], load_clock};
            lclk_d_r <= lclk_s_r[1];
            req_s_r <= {req_s_r[0], cfg_req_n};
            stat_s_r <= {stat_s_r[0], cfg_status_n_i};
            done_s_r <= {done_s_r[0], load_done_i};
            data_s1_r <= load_data;
            data_s2_r <= data_s1_r;
        end
    end

    // ===
    // Controller next state. A request low wins over every state.
    always @* begin
        state_nxt = state_r;
        por_cnt_nxt = por_cnt_r;
        phase_nxt = phase_r;
        count_nxt = count_r;
        fall_nxt = fall_r;
        push = 1'b0;
        if (!req_s_r[1]) begin
            // Any state is dropped, user mode too.
            state_nxt = `PPL_ST_HOLD; // R02
            phase_nxt = 4'h0;
            count_nxt = 32'h0000_0000;
            fall_nxt = 2'h0;
        end else begin
            case (state_r)
                `PPL_ST_POR: begin
                    // Status stays low for the whole delay.
                    if (por_cnt_r >= POR_CYCLES - 1) begin
                        state_nxt = `PPL_ST_LOAD; // R03
                    end else begin
                        por_cnt_nxt = por_cnt_r + 32'h0000_0001;
                    end
                end
                `PPL_ST_HOLD: begin
                    state_nxt = `PPL_ST_LOAD; // R02
                end
                `PPL_ST_LOAD: begin
                    // Edges count once the status line reads high;
                    // a pause with the clock low yields none.
                    if (lclk_rise & stat_s_r[1]) begin // R14
                        // The first edge of a group takes the word;
                        // the host holds it for the rest.
                        if (phase_r == 4'h0) begin // R17
                            if (!fifo_ready) begin
                                // Overflow loses data, so the load fails.
                                state_nxt = `PPL_ST_ERR; // R07
                            end else begin
                                push = 1'b1;
                                count_nxt = count_r + 32'h0000_0001;
                                if (count_nxt >= len_r) begin
                                    state_nxt = `PPL_ST_DONE; // R07
                                end
                            end
                        end
                        if (phase_r >= ratio - 4'h1) begin // R18
                            phase_nxt = 4'h0;
                        end else begin
                            phase_nxt = phase_r + 4'h1;
                        end
                    end
                end
                `PPL_ST_DONE: begin
                    // Falling edges count once the line is really high.
                    if (lclk_fall & done_s_r[1]) begin // R08
                        fall_nxt = fall_r + 2'h1;
                        if (fall_nxt == `PPL_INIT_EDGES) begin
                            state_nxt = `PPL_ST_USER; // R08
                        end
                    end
                end
                `PPL_ST_USER: begin
                    // Load clock activity has no effect here.
                    state_nxt = `PPL_ST_USER; // R09
                end
                `PPL_ST_ERR: begin
                    state_nxt = `PPL_ST_ERR;
                end
                default: begin
                    state_nxt = `PPL_ST_POR;
                end
            endcase
        end
    end

    // ===
    // Controller registers and open-drain pin controls.
    // Controls follow the next state to line up with it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= `PPL_ST_POR;
            por_cnt_r <= 32'h0000_0000;
            phase_r <= 4'h0;
            count_r <= 32'h0000_0000;
            fall_r <= 2'h0;
            cfg_status_n_o <= 1'b0;
            cfg_status_n_oe_n <= 1'b0;
            load_done_o <= 1'b0;
            load_done_oe_n <= 1'b0;
            init_done_o <= 1'b0;
            init_done_oe_n <= 1'b1;
            user_data_r <= 32'h0000_0000;
            user_mode_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            por_cnt_r <= por_cnt_nxt;
            phase_r <= phase_nxt;
            count_r <= count_nxt;
            fall_r <= fall_nxt;
            cfg_status_n_o <= 1'b0;
            load_done_o <= 1'b0;
            init_done_o <= 1'b0;
            // Status pulled low in power-on, request and error.
            cfg_status_n_oe_n <= ~((state_nxt == `PPL_ST_POR) | (state_nxt == `PPL_ST_HOLD) |
                                   (state_nxt == `PPL_ST_ERR)); // R03
            // Done low until the full count arrived.
            load_done_oe_n <= (state_nxt == `PPL_ST_DONE) | (state_nxt == `PPL_ST_USER); // R04
            // Init-done pulled low in user mode if enabled.
            init_done_oe_n <= ~((state_nxt == `PPL_ST_USER) & ctrl_r[`PPL_CTRL_INITEN_BIT]); // R13
            user_mode_r <= (state_nxt == `PPL_ST_USER); // R01
            // Data pins become plain user inputs.
            if (state_nxt == `PPL_ST_USER) begin
                user_data_r <= data_s2_r; // R12
            end else begin
                user_data_r <= 32'h0000_0000;
            end
        end
    end

    // ===
    // Word buffer toward the fabric. If it is full when
    // the host sends a further word, the load fails.
    ppl_fifo #(
        .WIDTH(32),
        .DEPTH(8),
        .AW(3)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_data(lanes_f(ctrl_r[`PPL_CTRL_WIDTH_MSB:`PPL_CTRL_WIDTH_LSB], data_s2_r)),
        .in_valid(push),
        .in_ready(fifo_ready),
        .out_data_r(cfg_word),
        .out_valid_r(cfg_valid),
        .out_ready(cfg_ready)
    );

    // ===
    // APB slave. One wait state: the answer is registered
    // in the first access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `PPL_CTRL_RST;
            len_r <= `PPL_LEN_RST;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_access;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (apb_access) begin
                case (paddr)
                    `PPL_OFS_CTRL: begin
                        if (pwrite) begin
                            ctrl_r <= pwdata[7:0];
                        end else begin
                            prdata <= {24'h00_0000, ctrl_r};
                        end
                    end
                    `PPL_OFS_LEN: begin
                        if (pwrite) begin
                            len_r <= pwdata;
                        end else begin
                            prdata <= len_r;
                        end
                    end
                    `PPL_OFS_STATUS: begin
                        if (!pwrite) begin
                            prdata <= {24'h00_0000, ~fifo_ready, cfg_valid, user_mode_r, phase_r[1:0], state_r};
                        end
                    end
                    `PPL_OFS_COUNT: begin
                        if (!pwrite) begin
                            prdata <= count_r;
                        end
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** inc/ppl_consts.vh ***
`ifndef PPL_CONSTS_VH
`define PPL_CONSTS_VH

// ===
// Register byte offsets on the APB bus.
`define PPL_OFS_CTRL 12'h000
`define PPL_OFS_LEN 12'h004
`define PPL_OFS_STATUS 12'h008
`define PPL_OFS_COUNT 12'h00C

// ===
// Control register fields and reset values.
`define PPL_CTRL_WIDTH_LSB 0
`define PPL_CTRL_WIDTH_MSB 1
`define PPL_CTRL_DECOMP_BIT 2
`define PPL_CTRL_SECURE_BIT 3
`define PPL_CTRL_INITEN_BIT 4
`define PPL_CTRL_RST 8'h02
`define PPL_LEN_RST 32'h0000_0010

// Bus width codes held in the control register.
`define PPL_WIDTH_8 2'h0
`define PPL_WIDTH_16 2'h1
`define PPL_WIDTH_32 2'h2

// ===
// Load clock cycles per data word.
`define PPL_RATIO_PLAIN 4'h1
`define PPL_RATIO_FEAT 4'h4

// Falling load clock edges before user mode.
`define PPL_INIT_EDGES 2'h2

// ===
// Controller states.
`define PPL_ST_POR 3'h0
`define PPL_ST_HOLD 3'h1
`define PPL_ST_LOAD 3'h2
`define PPL_ST_DONE 3'h3
`define PPL_ST_USER 3'h4
`define PPL_ST_ERR 3'h5

// ===
// Power-on delay in pclk cycles.
`define PPL_CLK_MHZ 200
`define PPL_POR_TIME_US 100
`define PPL_POR_CYCLES (`PPL_POR_TIME_US * `PPL_CLK_MHZ)

`endif

// *** tb/ppl_host_model.sv ***
`default_nettype none
// ===
// External host streaming words on an 80 ns load clock.
module ppl_host_model (
    output logic load_clock, // Load clock, still outside frames.
    output logic cfg_req_n, // Reconfiguration request.
    output logic [31:0] load_data // Data pins, all lanes driven.
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        load_clock = 1'b0;
        cfg_req_n = 1'b1;
        load_data = 32'h0000_0000;
    end
    // Pulse the request low to reconfigure.
    task automatic request();
        #41 cfg_req_n = 1'b0;
        #100 cfg_req_n = 1'b1;
    endtask
    // One word, held for r clocks; the last one stops at its capturing edge.
    task automatic send_word(input logic [31:0] d, input int r, input int gap, input bit last);
        #(gap);
        load_data = d;
        for (int i = 0; i < (last ? 1 : r); i++) begin
            #40 load_clock = 1'b1;
            if (!last) begin
                #40 load_clock = 1'b0;
            end
        end
        // Show the inverse so stale data never looks valid.
        if (!last) begin
            load_data = ~d;
        end
    endtask
    // One falling edge; the clock stays driven.
    task automatic fall_edge();
        #1;
        if (load_clock) begin
            #40 load_clock = 1'b0;
        end else begin
            #40 load_clock = 1'b1;
            #40 load_clock = 1'b0;
        end
    endtask
    task automatic set_data(input logic [31:0] d);
        load_data = d;
    endtask
endmodule
`default_nettype wire

// *** tb/ppl_loader_bench.sv ***
`include "ppl_consts.vh"
`default_nettype none
`define PPL_CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin mismatches++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
// ===
// Bench: bus master, fabric pacing and host stimulus.
module ppl_loader_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int POR = 20; // Short power-on delay.
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cfg_ready = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, cfg_word, user_data_r, load_data;
    logic pready, pslverr, load_clock, cfg_req_n, cfg_status_n_o, cfg_status_n_oe_n, cfg_valid;
    logic load_done_o, load_done_oe_n, init_done_o, init_done_oe_n, user_mode_r;
    logic [1:0] rdy_mode = 2'h0; // Fabric pacing: 0 always, 1 one in four, 2 stalled.
    logic [31:0] got[$]; // Words the fabric accepted.
    int mismatches = 0, num_checks = 0, cyc = 0;
    ppl_host_model host (.load_clock(load_clock), .cfg_req_n(cfg_req_n), .load_data(load_data));
    // Open-drain lines resolve to the pull-up unless driven low.
    ppl_loader #(.POR_CYCLES(POR)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .load_clock(load_clock),
        .cfg_req_n(cfg_req_n), .load_data(load_data), .cfg_status_n_o(cfg_status_n_o),
        .cfg_status_n_i(cfg_status_n_oe_n ? 1'b1 : cfg_status_n_o), .cfg_status_n_oe_n(cfg_status_n_oe_n),
        .load_done_i(load_done_oe_n ? 1'b1 : load_done_o), .load_done_o(load_done_o),
        .load_done_oe_n(load_done_oe_n), .init_done_o(init_done_o), .init_done_oe_n(init_done_oe_n),
        .cfg_word(cfg_word), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .user_data_r(user_data_r),
        .user_mode_r(user_mode_r));
    always #2.5 pclk = ~pclk;
    // Pace the fabric and record words taken.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        cfg_ready <= (rdy_mode == 2'h0) || (rdy_mode == 2'h1 && cyc % 4 == 0);
        if (cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
            got.push_back(cfg_word);
        end
    end
    function automatic logic [31:0] pat(input int i);
        return 32'h9E37_79B9 * (i + 1);
    endfunction
    // One bus transfer, held until ready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wait, bounded, until the status line is released.
    task automatic wait_status();
        for (int n = 0; n < 200 && cfg_status_n_oe_n !== 1'b1; n++) @(posedge pclk);
        #1;
    endtask
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        repeat (POR - 2) @(posedge pclk);
        `PPL_CHK("status_in_por", cfg_status_n_oe_n, 1'b0)
        `PPL_CHK("done_in_por", load_done_oe_n, 1'b0)
        apb(1'b0, `PPL_OFS_CTRL, 32'h0000_0000, q, e);
        `PPL_CHK("ctrl_reset", q, 32'h0000_0002)
        apb(1'b0, `PPL_OFS_LEN, 32'h0000_0000, q, e);
        `PPL_CHK("len_reset", q, 32'h0000_0010)
        apb(1'b1, `PPL_OFS_COUNT, 32'h0000_00FF, q, e);
        apb(1'b0, `PPL_OFS_COUNT, 32'h0000_0000, q, e);
        `PPL_CHK("count_ro", q, 32'h0000_0000)
        apb(1'b0, 12'h010, 32'h0000_0000, q, e);
        `PPL_CHK("unmapped_error", e, 1'b1)
        wait_status();
        `PPL_CHK("status_after_por", cfg_status_n_oe_n, 1'b1)
        $display("reset test finished");
    endtask
    // Full load, then initialisation and user mode.
    task automatic t_load(input logic [7:0] ctrl, input int n);
        logic [31:0] q, m;
        logic e;
        int r;
        r = (ctrl[2] || ctrl[3]) ? 4 : 1;
        m = ctrl[1:0] == 2'h0 ? 32'h0000_00FF : ctrl[1:0] == 2'h1 ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        apb(1'b1, `PPL_OFS_CTRL, {24'h00_0000, ctrl}, q, e);
        apb(1'b1, `PPL_OFS_LEN, n, q, e);
        host.request();
        wait_status();
        got.delete();
        for (int i = 0; i < n; i++) begin
            `PPL_CHK("done_low", load_done_oe_n, 1'b0)
            host.send_word(pat(i), r, i == 1 ? 500 : 0, i == n - 1);
        end
        repeat (10) @(posedge pclk);
        `PPL_CHK("done_released", load_done_oe_n, 1'b1)
        apb(1'b0, `PPL_OFS_COUNT, 32'h0000_0000, q, e);
        `PPL_CHK("words_taken", q, n)
        `PPL_CHK("words_out", got.size(), n)
        for (int i = 0; i < got.size(); i++) `PPL_CHK("word", got[i], pat(i) & m)
        host.fall_edge();
        repeat (10) @(posedge pclk);
        `PPL_CHK("one_edge", user_mode_r, 1'b0)
        host.fall_edge();
        repeat (10) @(posedge pclk);
        `PPL_CHK("user_mode", user_mode_r, 1'b1)
        `PPL_CHK("lines_high", {cfg_status_n_oe_n, load_done_oe_n}, 2'h3)
        `PPL_CHK("init_done", init_done_oe_n, !ctrl[4])
        repeat (3) host.fall_edge();
        host.set_data(32'h5A5A_0F0F);
        repeat (10) @(posedge pclk);
        `PPL_CHK("clock_ignored", {user_mode_r, cfg_valid}, 2'h2)
        `PPL_CHK("user_pins", user_data_r, 32'h5A5A_0F0F)
        $display("load test ctrl %0h words %0d finished", ctrl, n);
    endtask
    // Stalled fabric: a word beyond a full buffer fails the load.
    task automatic t_overflow();
        logic [31:0] q;
        logic e;
        rdy_mode <= 2'h2;
        apb(1'b1, `PPL_OFS_CTRL, 32'h0000_0002, q, e);
        apb(1'b1, `PPL_OFS_LEN, 32'h0000_0020, q, e);
        host.request();
        wait_status();
        for (int i = 0; i < 9; i++) host.send_word(pat(i), 1, 0, 1'b0);
        apb(1'b0, `PPL_OFS_STATUS, 32'h0000_0000, q, e);
        `PPL_CHK("buffer_full", {q[7], q[6]}, 2'h3)
        #1 host.send_word(pat(9), 1, 0, 1'b0);
        repeat (10) @(posedge pclk);
        `PPL_CHK("ovf_status", cfg_status_n_oe_n, 1'b0)
        `PPL_CHK("ovf_done", load_done_oe_n, 1'b0)
        rdy_mode <= 2'h0;
        repeat (20) @(posedge pclk);
        $display("overflow test finished");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // A hang counts as a mismatch.
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_load(8'h00, 5);
        t_load(8'h15, 4);
        t_overflow();
        rdy_mode <= 2'h1;
        t_load(8'h1A, 3);
        print_verdict();
    end
endmodule
`default_nettype wire

// *** tb/ppl_loader_props.sv ***
`include "ppl_consts.vh"
`default_nettype none
// ===
// Port checker for the loader.
module ppl_loader_props #(
    parameter POR_CYCLES = 20
) (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire logic psel, // Select.
    input wire logic penable, // Access phase.
    input wire logic pwrite, // Write.
    input wire logic [11:0] paddr, // Address.
    input wire logic [31:0] pwdata, // Write data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire logic cfg_req_n, // Request pin.
    input wire logic [31:0] load_data, // Data pins.
    input wire logic cfg_status_n_oe_n, // Status drive.
    input wire logic load_done_oe_n, // Done drive.
    input wire logic init_done_oe_n, // Init drive.
    input wire logic [31:0] cfg_word, // Head word.
    input wire logic cfg_valid, // Head present.
    input wire logic cfg_ready, // Head taken.
    input wire logic [31:0] user_data_r, // User pins.
    input wire logic user_mode_r // User mode.
);
    int por_cnt; // Edges since reset release, saturating.
    logic init_en_r; // Shadow of the init enable bit.
    // Track the power-on window and the written init enable.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_cnt <= 0;
            init_en_r <= 1'b0;
        end else begin
            if (por_cnt < POR_CYCLES) begin
                por_cnt <= por_cnt + 1;
            end
            if (psel && penable && pready && pwrite && paddr == `PPL_OFS_CTRL) begin
                init_en_r <= pwdata[`PPL_CTRL_INITEN_BIT];
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_por_status_low: assert property (por_cnt < POR_CYCLES |-> !cfg_status_n_oe_n)
        else $error("status released early");
    a_user_lines_high: assert property (user_mode_r |-> cfg_status_n_oe_n && load_done_oe_n)
        else $error("line driven low in user mode");
    a_req_restarts: assert property ($fell(cfg_req_n) |->
        ##[1:5] (!user_mode_r && !load_done_oe_n && !cfg_status_n_oe_n))
        else $error("request ignored");
    a_done_clean: assert property ($rose(load_done_oe_n) |-> cfg_status_n_oe_n && cfg_req_n)
        else $error("done released wrongly");
    a_user_stays: assert property (user_mode_r && cfg_req_n && $past(cfg_req_n) |=> user_mode_r)
        else $error("user mode lost");
    a_user_pins: assert property ((user_mode_r && $stable(load_data)) [*4] |->
        user_data_r == load_data)
        else $error("user data stale");
    a_init_drive: assert property (init_done_oe_n == !(user_mode_r && init_en_r))
        else $error("init output drive wrong");
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("bus answer late");
    a_apb_err_map: assert property (pready |-> pslverr == (paddr > 12'h00C || paddr[1:0] != 2'h0))
        else $error("bus error flag wrong");
    a_head_held: assert property (cfg_valid && !cfg_ready && cfg_req_n |=> cfg_valid && $stable(cfg_word))
        else $error("head word changed");
    c_user: cover property ($rose(user_mode_r));
    c_err: cover property (pready && pslverr);
    c_stall: cover property (cfg_valid && !cfg_ready);
endmodule

bind ppl_loader ppl_loader_props #(.POR_CYCLES(POR_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .cfg_req_n(cfg_req_n),
    .load_data(load_data), .cfg_status_n_oe_n(cfg_status_n_oe_n), .load_done_oe_n(load_done_oe_n),
    .init_done_oe_n(init_done_oe_n), .cfg_word(cfg_word), .cfg_valid(cfg_valid),
    .cfg_ready(cfg_ready), .user_data_r(user_data_r), .user_mode_r(user_mode_r)
);
`default_nettype wire
